// *** rtl/hms_pkg.sv ***
// constants, types and state codes of the hoist motor sequencer
// assumes a 200 MHz sys_clk and switch inputs synchronous to it
//
// Behaviour
// - selector code picks slow, fast, reversal, start and stop times from fixed sets
// - selector code F (inverter operation) makes all five times zero
// - selector codes 8, 9 and B to E use the code 7 set, the longest one
// - operating hours accumulate only while a hoist output is energised
// - hoist thermistor trip flags an error and blocks all four hoist outputs
// - hoist motion stays blocked until the hoist thermistor reports cool
// - travel thermistor trip drops left and right relays and raises a warning
// - travel warning clears itself and travel relays return once the motor cools
// - suppress switch hides the travel warning; travel relays still follow the thermistor
// - polarity switches make fault and aux relays normally-open or normally-closed
// - fault relay operates in every error that stops lifting
// - three-bit field picks the aux relay source: never, overload, heat, sensor, any
// - field 101 drops the aux relay for 500 ms on overload, then restores it
// - field 110 switches the aux relay at 95 percent of nominal load
// - slow output comes first; fast joins only after the start delay
// - on release fast drops first, slow follows after the stop delay
// - a quick re-request waits out the slow or fast off-time
// - reversal stops the hoist and waits the reversal off-time first

package hms_pkg;

   localparam int TW = 12;
   typedef logic [TW-1:0] hms_ms_t;

   typedef struct packed {
      hms_ms_t slow_off;
      hms_ms_t fast_off;
      hms_ms_t rev_off;
      hms_ms_t start_dly;
      hms_ms_t stop_dly;
   } hms_times_t;

   // timing sets, ms: slow off, fast off, reversal, start, stop
   localparam hms_times_t SET_LONG  = '{12'h258, 12'h4e2, 12'h4e2, 12'h1f4, 12'h1f4};
   localparam hms_times_t SET_SHORT = '{12'h0fa, 12'h1f4, 12'h1f4, 12'h000, 12'h0fa};
   localparam hms_times_t SET_MID   = '{12'h190, 12'h2ee, 12'h2ee, 12'h12c, 12'h12c};
   localparam hms_times_t SET_M6    = '{12'h190, 12'h2ee, 12'h2ee, 12'h190, 12'h190};
   localparam hms_times_t SET_EX    = '{12'h190, 12'h2ee, 12'h2ee, 12'h000, 12'h000};
   localparam hms_times_t SET_INV   = '{12'h000, 12'h000, 12'h000, 12'h000, 12'h000};

   localparam logic [3:0] SEL_UNKNOWN = 4'h0;
   localparam logic [3:0] SEL_SHORT_LO = 4'h1;
   localparam logic [3:0] SEL_SHORT_HI = 4'h3;
   localparam logic [3:0] SEL_MID_LO = 4'h4;
   localparam logic [3:0] SEL_MID_HI = 4'h5;
   localparam logic [3:0] SEL_M6 = 4'h6;
   localparam logic [3:0] SEL_LONG = 4'h7;
   localparam logic [3:0] SEL_EX = 4'ha;
   localparam logic [3:0] SEL_INV = 4'hf;

   // aux relay source field, {bit2, bit1, bit0}
   localparam logic [2:0] AUX_NEVER = 3'h0;
   localparam logic [2:0] AUX_OVERLOAD = 3'h1;
   localparam logic [2:0] AUX_HEAT = 3'h2;
   localparam logic [2:0] AUX_SENSOR = 3'h3;
   localparam logic [2:0] AUX_ANY_ERR = 3'h4;
   localparam logic [2:0] AUX_OVL_PULSE = 3'h5;
   localparam logic [2:0] AUX_LOAD95 = 3'h6;

   localparam hms_ms_t AUX_PULSE_MS = 12'h1f4;
   localparam hms_ms_t MS_SAT = 12'hfff;

   localparam int unsigned CLK_PERIOD_NS = 5;
   localparam int unsigned NS_PER_MS = 1000000;
   localparam int unsigned CYC_PER_MS = NS_PER_MS / CLK_PERIOD_NS;
   localparam int unsigned MS_PER_HOUR = 3600000;
   localparam int HOUR_W = 20;

   typedef enum logic [4:0] {
      ST_IDLE  = 5'b00001,
      ST_WAIT  = 5'b00010,
      ST_SLOW  = 5'b00100,
      ST_FAST  = 5'b01000,
      ST_DECEL = 5'b10000
   } hms_state_t;

endpackage

// *** rtl/hms_tmr_if.sv ***
// timing bundle between the selector/tick module and the sequencer
// assumes both ends run on sys_clk
`timescale 1ns/1ps

interface hms_tmr_if;
   import hms_pkg::*;
   logic tick;
   hms_times_t times;
   logic motion_idle;
   modport src (output tick, output times, input motion_idle);
   modport use_end (input tick, input times, output motion_idle);
endinterface

// *** rtl/hms_timing.sv ***
// millisecond tick and selector-driven timing set
// assumes the selector is synchronous to sys_clk
`timescale 1ns/1ps

module hms_timing
   import hms_pkg::*;
#(
   parameter int unsigned CYCLES_PER_MS = CYC_PER_MS
)
(
   input wire logic sys_clk, // system clock
   input wire logic rst, // async reset, active high
   input wire logic [3:0] motor_type_selector, // timing set code
   hms_tmr_if.src tif // tick and times out
);

   function automatic hms_times_t decode_set(input logic [3:0] code);
      hms_times_t t;
      t = SET_LONG;
      if (code == SEL_UNKNOWN)
         t = SET_LONG;
      else if (code >= SEL_SHORT_LO && code <= SEL_SHORT_HI)
         t = SET_SHORT;
      else if (code == SEL_MID_LO || code == SEL_MID_HI)
         t = SET_MID;
      else if (code == SEL_M6)
         t = SET_M6;
      else if (code == SEL_EX)
         t = SET_EX;
      else if (code == SEL_INV)
         t = SET_INV;
      return t;
   endfunction

   logic [31:0] div_q, div_d;
   logic tick_q, tick_d;
   logic [3:0] sel_q, sel_d;
   hms_times_t times_q, times_d;

   always_comb
   begin
      tick_d = (div_q == 32'(CYCLES_PER_MS - 1));
      div_d = tick_d ? 32'h0 : div_q + 32'h1;
      sel_d = motor_type_selector;
      times_d = tif.motion_idle ? decode_set(sel_q) : times_q;
   end

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         div_q <= 32'h0;
         tick_q <= 1'b0;
         sel_q <= SEL_UNKNOWN;
         times_q <= SET_LONG;
      end
      else
      begin
         div_q <= div_d;
         tick_q <= tick_d;
         sel_q <= sel_d;
         times_q <= times_d;
      end
   end

   assign tif.tick = tick_q;
   assign tif.times = times_q;

   ////////////////////////////////////////////////////////////////////////////
   chk_inv_zero: assert property (@(posedge sys_clk) disable iff (rst)
      (sel_q == SEL_INV && tif.motion_idle) |=> (times_q == SET_INV))
      else $error("inverter code did not give zero times");

endmodule

// *** rtl/hms_sequencer.sv ***
// hoist motor sequencer: lift/lower relays, thermistors, signalling relays
// assumes all inputs are synchronous, debounced levels on sys_clk
`timescale 1ns/1ps

module hms_sequencer
   import hms_pkg::*;
#(
   parameter int unsigned CYCLES_PER_MS = CYC_PER_MS,
   parameter int unsigned MS_PER_HR = MS_PER_HOUR
)
(
   input wire logic sys_clk, // system clock, 200 MHz
   input wire logic rst, // async reset, active high
   input wire logic [3:0] motor_type_selector, // timing set code
   input wire logic inverter_mode_switch, // installer sets with code f
   input wire logic travel_warn_suppress, // hide travel warning
   input wire logic aux_relay_src_bit0, // aux source field bit 0
   input wire logic aux_relay_src_bit1, // aux source field bit 1
   input wire logic aux_relay_src_bit2, // aux source field bit 2
   input wire logic fault_relay_polarity, // 1 = normally closed
   input wire logic aux_relay_polarity, // 1 = normally closed
   input wire logic req_lift, // operator lift request
   input wire logic req_lower, // operator lower request
   input wire logic req_fast, // operator fast speed request
   input wire logic hoist_therm_trip, // hoist motor too hot
   input wire logic travel_therm_trip, // travel motor too hot
   input wire logic travel_left_req, // travel left request
   input wire logic travel_right_req, // travel right request
   input wire logic overload, // overload detected
   input wire logic sensor_error, // load sensor error
   input wire logic load_95pct, // load at 95 percent of nominal
   output logic out_lift_slow, // lift relay
   output logic out_lift_fast, // lift fast relay
   output logic out_lower_slow, // lower relay
   output logic out_lower_fast, // lower fast relay
   output logic travel_left, // travel left relay
   output logic travel_right, // travel right relay
   output logic led_error, // error indicator
   output logic led_warn, // travel warning indicator
   output logic fault_relay, // fault signalling relay coil
   output logic aux_relay, // aux signalling relay coil
   output logic [HOUR_W-1:0] hours_count // operating hours
);

   function automatic logic relay_coil(input logic active, input logic nc);
      return active ^ nc;
   endfunction
   hms_tmr_if tif ();
   hms_timing #(.CYCLES_PER_MS(CYCLES_PER_MS)) u_timing (
      .sys_clk(sys_clk),
      .rst(rst),
      .motor_type_selector(motor_type_selector),
      .tif(tif)
   );

   ////////////////////////////////////////////////////////////////////////////
   // hoist sequencing
   hms_state_t state_q, state_d;
   logic dir_q, dir_d; // 1 = lift
   logic last_dir_q, last_dir_d;
   logic last_fast_q, last_fast_d;
   hms_ms_t step_q, step_d, rest_q, rest_d;
   logic lift_slow_q, lift_slow_d, lift_fast_q, lift_fast_d;
   logic lower_slow_q, lower_slow_d, lower_fast_q, lower_fast_d;
   logic lift_rq, lower_rq, want, want_dir, fast_rq;
   logic blk_lift, blk_lower, dir_ok, cur_ok, hold, step_clr, rest_clr, slow_on, fast_on;
   hms_ms_t need;
   always_comb
   begin
      lift_rq = req_lift & ~req_lower;
      lower_rq = req_lower & ~req_lift;
      want = lift_rq | lower_rq;
      want_dir = lift_rq;
      fast_rq = req_fast & want;
      blk_lift = hoist_therm_trip | overload | sensor_error;
      blk_lower = hoist_therm_trip;
      dir_ok = want & (want_dir ? ~blk_lift : ~blk_lower);
      cur_ok = dir_q ? ~blk_lift : ~blk_lower;
      hold = want & (want_dir == dir_q) & cur_ok;
      if (want_dir != last_dir_q)
         need = tif.times.rev_off;
      else if (last_fast_q)
         need = tif.times.fast_off;
      else
         need = tif.times.slow_off;
      state_d = state_q;
      dir_d = dir_q;
      last_dir_d = last_dir_q;
      last_fast_d = last_fast_q;
      step_clr = 1'b0;
      rest_clr = 1'b0;
      case (state_q)
         ST_IDLE:
         begin
            if (dir_ok)
            begin
               dir_d = want_dir;
               step_clr = 1'b1;
               state_d = (rest_q >= need) ? ST_SLOW : ST_WAIT;
            end
         end
         ST_WAIT:
         begin
            if (!dir_ok || want_dir != dir_q)
               state_d = ST_IDLE;
            else if (rest_q >= need)
            begin
               step_clr = 1'b1;
               state_d = ST_SLOW;
            end
         end
         ST_SLOW:
         begin
            if (!hold)
            begin
               state_d = ST_IDLE;
               last_dir_d = dir_q;
               last_fast_d = 1'b0;
               rest_clr = 1'b1;
            end
            else if (fast_rq && step_q >= tif.times.start_dly)
            begin
               step_clr = 1'b1;
               state_d = ST_FAST;
            end
         end
         ST_FAST:
         begin
            if (!cur_ok)
            begin
               state_d = ST_IDLE;
               last_dir_d = dir_q;
               last_fast_d = 1'b1;
               rest_clr = 1'b1;
            end
            else if (!hold)
            begin
               step_clr = 1'b1;
               state_d = ST_DECEL;
            end
            else if (!fast_rq)
            begin
               step_clr = 1'b1;
               state_d = ST_SLOW;
            end
         end
         ST_DECEL:
         begin
            if (!cur_ok || step_q >= tif.times.stop_dly)
            begin
               state_d = ST_IDLE;
               last_dir_d = dir_q;
               last_fast_d = 1'b1;
               rest_clr = 1'b1;
            end
         end
         default: state_d = ST_IDLE;
      endcase
      step_d = step_q;
      if (step_clr)
         step_d = '0;
      else if (tif.tick && step_q != MS_SAT)
         step_d = step_q + hms_ms_t'(1);
      rest_d = rest_q;
      if (rest_clr)
         rest_d = '0;
      else if (tif.tick && rest_q != MS_SAT)
         rest_d = rest_q + hms_ms_t'(1);
      slow_on = (state_d == ST_SLOW) | (state_d == ST_FAST) | (state_d == ST_DECEL);
      fast_on = (state_d == ST_FAST);
      lift_slow_d = slow_on & dir_d;
      lift_fast_d = fast_on & dir_d;
      lower_slow_d = slow_on & ~dir_d;
      lower_fast_d = fast_on & ~dir_d;
   end
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         state_q <= ST_IDLE;
         dir_q <= 1'b0;
         last_dir_q <= 1'b0;
         last_fast_q <= 1'b0;
         step_q <= '0;
         rest_q <= MS_SAT;
         lift_slow_q <= 1'b0;
         lift_fast_q <= 1'b0;
         lower_slow_q <= 1'b0;
         lower_fast_q <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         dir_q <= dir_d;
         last_dir_q <= last_dir_d;
         last_fast_q <= last_fast_d;
         step_q <= step_d;
         rest_q <= rest_d;
         lift_slow_q <= lift_slow_d;
         lift_fast_q <= lift_fast_d;
         lower_slow_q <= lower_slow_d;
         lower_fast_q <= lower_fast_d;
      end
   end

   assign tif.motion_idle = ~(lift_slow_q | lower_slow_q);
   ////////////////////////////////////////////////////////////////////////////
   // operating hours, travel, indicators, signalling relays
   logic [31:0] ms_acc_q, ms_acc_d;
   logic [HOUR_W-1:0] hours_q, hours_d;
   hms_ms_t pulse_q, pulse_d;
   logic [2:0] aux_src;
   logic aux_act, err_act, ovl_q, ovl_d;
   logic tl_q, tl_d, tr_q, tr_d, lerr_q, lerr_d, lwarn_q, lwarn_d;
   logic frel_q, frel_d, arel_q, arel_d;
   always_comb
   begin
      ms_acc_d = ms_acc_q;
      hours_d = hours_q;
      if (tif.tick && !tif.motion_idle)
      begin
         if (ms_acc_q == 32'(MS_PER_HR - 1))
         begin
            ms_acc_d = 32'h0;
            hours_d = hours_q + HOUR_W'(1);
         end
         else
            ms_acc_d = ms_acc_q + 32'h1;
      end
      tl_d = travel_left_req & ~travel_therm_trip;
      tr_d = travel_right_req & ~travel_therm_trip;
      lwarn_d = travel_therm_trip & ~travel_warn_suppress;
      lerr_d = hoist_therm_trip | overload | sensor_error;
      err_act = blk_lift;
      frel_d = relay_coil(err_act, fault_relay_polarity);
      ovl_d = overload;
      aux_src = {aux_relay_src_bit2, aux_relay_src_bit1, aux_relay_src_bit0};
      pulse_d = pulse_q;
      if (aux_src != AUX_OVL_PULSE)
         pulse_d = '0;
      else if (overload && !ovl_q)
         pulse_d = AUX_PULSE_MS;
      else if (tif.tick && pulse_q != '0)
         pulse_d = pulse_q - hms_ms_t'(1);
      case (aux_src)
         AUX_NEVER: aux_act = 1'b0;
         AUX_OVERLOAD: aux_act = overload;
         AUX_HEAT: aux_act = hoist_therm_trip | travel_therm_trip;
         AUX_SENSOR: aux_act = sensor_error;
         AUX_ANY_ERR: aux_act = blk_lift;
         AUX_OVL_PULSE: aux_act = (pulse_q == '0);
         AUX_LOAD95: aux_act = load_95pct;
         default: aux_act = 1'b0;
      endcase
      arel_d = relay_coil(aux_act, aux_relay_polarity);
   end
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         ms_acc_q <= 32'h0;
         hours_q <= '0;
         ovl_q <= 1'b0;
         pulse_q <= '0;
         tl_q <= 1'b0;
         tr_q <= 1'b0;
         lerr_q <= 1'b0;
         lwarn_q <= 1'b0;
         frel_q <= 1'b0;
         arel_q <= 1'b0;
      end
      else
      begin
         ms_acc_q <= ms_acc_d;
         hours_q <= hours_d;
         ovl_q <= ovl_d;
         pulse_q <= pulse_d;
         tl_q <= tl_d;
         tr_q <= tr_d;
         lerr_q <= lerr_d;
         lwarn_q <= lwarn_d;
         frel_q <= frel_d;
         arel_q <= arel_d;
      end
   end
   assign out_lift_slow = lift_slow_q;
   assign out_lift_fast = lift_fast_q;
   assign out_lower_slow = lower_slow_q;
   assign out_lower_fast = lower_fast_q;
   assign travel_left = tl_q;
   assign travel_right = tr_q;
   assign led_error = lerr_q;
   assign led_warn = lwarn_q;
   assign fault_relay = frel_q;
   assign aux_relay = arel_q;
   assign hours_count = hours_q;
   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   chk_hoist_block: assert property (hoist_therm_trip |=>
      !(lift_slow_q || lift_fast_q || lower_slow_q || lower_fast_q) && led_error)
      else $error("hoist outputs not blocked on thermistor trip");
   chk_hoist_cool: assert property (hoist_therm_trip[*3] |->
      (state_q == ST_IDLE || state_q == ST_WAIT))
      else $error("hoist moved while still hot");
   chk_start_order: assert property ($rose(lift_fast_q) |-> $past(lift_slow_q)
      && lift_slow_q)
      else $error("fast lift before slow lift");
   chk_stop_decel: assert property ((state_q == ST_FAST && state_d == ST_DECEL)
      |=> !(lift_fast_q || lower_fast_q) && (lift_slow_q || lower_slow_q))
      else $error("stop deceleration order wrong");
   chk_restart_wait: assert property ((state_q == ST_WAIT) |->
      !(lift_slow_q || lower_slow_q))
      else $error("output on during off-time");
   chk_travel_off: assert property (travel_therm_trip |=>
      !travel_left && !travel_right)
      else $error("travel relays on while travel motor hot");
   chk_travel_back: assert property ((!travel_therm_trip && travel_left_req)
      |=> travel_left && !led_warn)
      else $error("travel not restored after cooling");
   chk_warn_supp: assert property ((travel_warn_suppress && travel_therm_trip)
      |=> !led_warn && !travel_left && !travel_right)
      else $error("travel warning not suppressed");
   chk_fault_relay: assert property (blk_lift |=>
      (fault_relay != $past(fault_relay_polarity)))
      else $error("fault relay not operated on lift-stopping error");
   chk_aux_pulse: assert property ((aux_src == AUX_OVL_PULSE && overload && !ovl_q
      && !aux_relay_polarity) ##1 (aux_src == AUX_OVL_PULSE && !aux_relay_polarity)
      |=> !aux_relay)
      else $error("aux relay not dropped on overload pulse");
   cov_fast_lift: cover property (state_q == ST_FAST && dir_q);
   cov_reversal: cover property ((state_q == ST_WAIT) && (last_dir_q != dir_q));
   cov_aux_pulse: cover property ((aux_src == AUX_OVL_PULSE) && (pulse_q != '0));
   cov_inverter: cover property (motor_type_selector == SEL_INV && inverter_mode_switch);

endmodule

// *** dv/hms_pendant_model.sv ***
// pendant, selector and installer switch model facing the sequencer
// assumes the bench changes its commands at the falling clock edge
`timescale 1ns/1ps

module hms_pendant_model
(
   input wire logic [3:0] sel_cmd, // wanted motor type code
   input wire logic lift_cmd, // operator presses lift
   input wire logic lower_cmd, // operator presses lower
   input wire logic fast_cmd, // operator presses fast
   output logic [3:0] motor_type_selector, // selector switch
   output logic inverter_mode_switch, // installer switch
   output logic req_lift, // lift contact
   output logic req_lower, // lower contact
   output logic req_fast // fast contact
);
   always_comb
   begin
      motor_type_selector = sel_cmd;
      inverter_mode_switch = (sel_cmd == 4'hf);
      req_lift = lift_cmd;
      req_lower = lower_cmd;
      req_fast = fast_cmd;
   end
endmodule

// *** dv/tb_hms_sequencer.sv ***
// self-checking bench for the hoist motor sequencer
// assumes a 5 ns clock and a millisecond tick of 4 cycles
`timescale 1ns/1ps

module tb_hms_sequencer
   import hms_pkg::*;
   ;
   localparam int C = 4;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic [3:0] sel_cmd = 4'h1;
   logic lift_cmd = 1'b0, lower_cmd = 1'b0, fast_cmd = 1'b0;
   logic sup = 1'b0, a0 = 1'b0, a1 = 1'b0, a2 = 1'b0, fpol = 1'b0, apol = 1'b0;
   logic htrip = 1'b0, ttrip = 1'b0, tl = 1'b0, tr = 1'b0;
   logic ovl = 1'b0, serr = 1'b0, l95 = 1'b0;
   wire logic [3:0] sel;
   wire logic inv, rl, rd, rf, ols, olf, ows, owf, trl, trr, lerr, lwarn, frel, arel;
   wire logic [HOUR_W-1:0] hrs;
   int err_count = 0;
   int cmp_count = 0;
   int cnt;
   logic [3:0] codes [7] = '{4'h0, 4'h4, 4'h6, 4'h7, 4'h8, 4'ha, 4'hf};
   int td [7] = '{500, 300, 400, 500, 500, 0, 0};

   always #2.5 sys_clk = ~sys_clk;

   hms_pendant_model hms_pendant_model_inst (.sel_cmd(sel_cmd), .lift_cmd(lift_cmd),
      .lower_cmd(lower_cmd), .fast_cmd(fast_cmd), .motor_type_selector(sel),
      .inverter_mode_switch(inv), .req_lift(rl), .req_lower(rd), .req_fast(rf));

   hms_sequencer #(.CYCLES_PER_MS(C), .MS_PER_HR(10)) hms_sequencer_inst (
      .sys_clk(sys_clk), .rst(rst), .motor_type_selector(sel), .inverter_mode_switch(inv),
      .travel_warn_suppress(sup), .aux_relay_src_bit0(a0), .aux_relay_src_bit1(a1),
      .aux_relay_src_bit2(a2), .fault_relay_polarity(fpol), .aux_relay_polarity(apol),
      .req_lift(rl), .req_lower(rd), .req_fast(rf), .hoist_therm_trip(htrip),
      .travel_therm_trip(ttrip), .travel_left_req(tl), .travel_right_req(tr),
      .overload(ovl), .sensor_error(serr), .load_95pct(l95), .out_lift_slow(ols),
      .out_lift_fast(olf), .out_lower_slow(ows), .out_lower_fast(owf), .travel_left(trl),
      .travel_right(trr), .led_error(lerr), .led_warn(lwarn), .fault_relay(frel),
      .aux_relay(arel), .hours_count(hrs));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      cmp_count++;
      if (s !== e)
      begin
         err_count++;
         $display("unexpected %s expected %0h seen %0h", n, e, s);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge sys_clk);
   endtask

   task automatic cmd(input logic l, input logic d, input logic f);
      lift_cmd = l;
      lower_cmd = d;
      fast_cmd = f;
   endtask

   // tick granularity allows one ms short plus a few pipeline cycles
   function automatic logic near(input int n, input int t);
      return n >= (t - 1) * C && n <= t * C + 4;
   endfunction

   task automatic final_report();
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      chk("idle outputs", {ols, olf, ows, owf, trl, trr, lerr, lwarn, frel, arel}, 10'h0);
      chk("hours", hrs, 20'h0);
      fpol = 1'b1;
      cyc(2);
      chk("fault closed", frel, 1'b1);
      $display("test reset done");
   endtask

   task automatic t_run();
      cmd(1'b1, 1'b0, 1'b1);
      for (int i = 0; i < 4 && ols !== 1'b1; i++) cyc(1);
      chk("slow first", {ols, olf}, 2'b10);
      cyc(2);
      chk("fast joins", {ols, olf}, 2'b11);
      cyc(12 * C);
      chk("hours", hrs, 20'h1);
      cmd(1'b0, 1'b0, 1'b0);
      cyc(2);
      chk("fast drops", {ols, olf}, 2'b10);
      cyc(240 * C);
      chk("decel hold", ols, 1'b1);
      for (int i = 0; i < 20 * C && ols !== 1'b0; i++) cyc(1);
      chk("decel end", ols, 1'b0);
      cmd(1'b1, 1'b0, 1'b0);
      cyc(480 * C);
      chk("fast offtime", ols, 1'b0);
      for (int i = 0; i < 40 * C && ols !== 1'b1; i++) cyc(1);
      chk("restart", ols, 1'b1);
      cmd(1'b0, 1'b1, 1'b0);
      cyc(480 * C);
      chk("reversal wait", {ols, ows}, 2'b00);
      for (int i = 0; i < 40 * C && ows !== 1'b1; i++) cyc(1);
      chk("reversed", ows, 1'b1);
      cmd(1'b0, 1'b0, 1'b0);
      cyc(3);
      chk("slow release", ows, 1'b0);
      $display("test run done");
   endtask

   task automatic t_codes();
      foreach (codes[k])
      begin
         sel_cmd = codes[k];
         cyc(3);
         cmd(1'b1, 1'b0, 1'b1);
         for (int i = 0; i < 1300 * C && ols !== 1'b1; i++) cyc(1);
         cnt = 0;
         while (cnt < 600 * C && olf !== 1'b1)
         begin
            cyc(1);
            cnt++;
         end
         chk("start delay", near(cnt, td[k]), 1'b1);
         cmd(1'b0, 1'b0, 1'b0);
         cnt = 0;
         while (cnt < 600 * C && ols !== 1'b0)
         begin
            cyc(1);
            cnt++;
         end
         chk("stop delay", near(cnt, td[k]), 1'b1);
      end
      $display("test codes done");
   endtask

   task automatic t_therm();
      cmd(1'b1, 1'b0, 1'b0);
      cyc(4);
      chk("lift on", ols, 1'b1);
      htrip = 1'b1;
      cyc(2);
      chk("hoist trip", {ols, lerr, frel}, 3'b010);
      cmd(1'b0, 1'b1, 1'b1);
      cyc(4);
      chk("lower blocked", {ows, owf}, 2'b00);
      htrip = 1'b0;
      cyc(4);
      chk("cooled", {ows, owf, lerr, frel}, 4'b1101);
      cmd(1'b0, 1'b0, 1'b0);
      $display("test therm done");
   endtask

   task automatic t_travel();
      tl = 1'b1;
      tr = 1'b1;
      cyc(2);
      chk("travel on", {trl, trr, lwarn}, 3'b110);
      ttrip = 1'b1;
      cyc(2);
      chk("travel hot", {trl, trr, lwarn}, 3'b001);
      sup = 1'b1;
      cyc(2);
      chk("warn hidden", {trl, trr, lwarn}, 3'b000);
      sup = 1'b0;
      ttrip = 1'b0;
      cyc(2);
      chk("travel back", {trl, trr, lwarn}, 3'b110);
      $display("test travel done");
   endtask

   // cause bits are load95, sensor, hoist heat, overload
   task automatic aux_case(input logic [2:0] f, input logic [3:0] c, input logic e);
      {a2, a1, a0} = f;
      {l95, serr, htrip, ovl} = c;
      cyc(3);
      chk("aux relay", arel, e ^ apol);
      chk("fault relay", frel, (c[2] | c[1] | c[0]) ^ fpol);
      {l95, serr, htrip, ovl} = 4'h0;
      cyc(3);
      chk("aux idle", arel, apol);
   endtask

   task automatic t_aux();
      aux_case(3'h0, 4'h1, 1'b0);
      aux_case(3'h1, 4'h1, 1'b1);
      aux_case(3'h2, 4'h2, 1'b1);
      aux_case(3'h3, 4'h4, 1'b1);
      aux_case(3'h4, 4'h4, 1'b1);
      apol = 1'b1;
      aux_case(3'h6, 4'h8, 1'b1);
      apol = 1'b0;
      {a2, a1, a0} = 3'h5;
      cyc(3);
      chk("pulse idle", arel, 1'b1);
      ovl = 1'b1;
      cyc(3);
      chk("pulse off", arel, 1'b0);
      cyc(490 * C);
      chk("pulse hold", arel, 1'b0);
      cyc(20 * C);
      chk("pulse end", arel, 1'b1);
      ovl = 1'b0;
      $display("test aux done");
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (5) @(negedge sys_clk);
      rst = 1'b0;
      cyc(2);
      t_reset();
      t_run();
      t_codes();
      t_therm();
      t_travel();
      t_aux();
      final_report();
   end

   initial
   begin
      repeat (100000) @(posedge sys_clk);
      err_count++;
      $display("watchdog expired");
      final_report();
   end
endmodule
